// *** logic/acmp_top.sv ***
`timescale 1ns/100ps
`include "acmp_consts.svh"

module acmp_top #(
  parameter int NUM = 4,
  parameter int CODE_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // register access port
  input wire acmp_pkg::acmp_addr_t reg_addr,
  input wire acmp_pkg::acmp_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output acmp_pkg::acmp_word_t reg_rdata,
  // converter results as they are stored
  input wire logic meas_valid,
  input wire logic [2:0] meas_channel,
  input wire acmp_pkg::acmp_code_t meas_code,
  // flags and the gated event toward the system interrupt
  output logic [3:0] comparator_event_flag,
  output logic comparator_irq
);
  import acmp_pkg::*;

  // the whole block state lives in one packed struct so the reset
  // branch and the next-state logic cannot drift apart field by field
  acmp_state_t st; // registered state
  acmp_state_t next_st; // value for the next edge
  logic [NUM-1:0] hit; // per-comparator test on the incoming code
  logic [NUM-1:0] sel_match; // incoming sample is on the chosen channel
  logic [NUM-1:0] new_cond; // condition after this cycle
  logic [NUM-1:0] rise; // condition just became true
  logic status_read; // reading the status register clears flags
  logic [NUM-1:0][CODE_W-1:0] sel_code; // newest code per comparator

  // each comparator reads the newest code of its own channel: the
  // sample arriving now when it is on that channel, else the stored
  // one; a matching sample bypasses the per-channel store in the
  // cycle it arrives, and is written into it at the same edge
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      if (meas_valid
          && (meas_channel == st.comparator_source_select[i])) begin
        // fresh sample wins, it is stored at this very edge
        sel_code[i] = meas_code;
      end else begin
        // no sample for this channel now, use the stored one
        sel_code[i] = st.latest[st.comparator_source_select[i]];
      end
    end
  end

  // every comparator tests its own code; the channel match below
  // decides whether the result is used, so sharing a channel is free
  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi++) begin : g_cmp
      acmp_threshold #(
        .WIDTH(CODE_W)
      ) u_thr (
        .code(sel_code[gi]),
        .limit(st.comparator_limit_value[gi]),
        .above(st.comparator_above_select[gi]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // channel match, condition tracking and rising edge detection
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      sel_match[i] = meas_valid
                     && (meas_channel == st.comparator_source_select[i]);
      if (!st.comparator_enable[i]) begin
        // a disabled comparator holds its condition low, so enabling
        // it later lets the next beyond-limit sample raise the flag
        new_cond[i] = 1'b0;
      end else if (sel_match[i]) begin
        // a sample of the chosen channel re-evaluates the verdict
        new_cond[i] = hit[i];
      end else begin
        // no sample of this channel: hold the last verdict
        new_cond[i] = st.cond[i];
      end
      // only a 0 to 1 step raises a flag; a level that stays beyond
      // the limit must not re-flag after software has cleared it
      rise[i] = new_cond[i] && !st.cond[i];
    end
  end

  // a status read is recognised on the strobe edge itself, so the
  // flags it reports and the flags it clears are the same snapshot
  assign status_read = reg_rd && (reg_addr == `ACMP_OFF_INT_STATUS);

  // next state: register writes, sample store, flags and read data
  always_comb begin
    next_st = st;
    // keep the most recent code of every channel
    if (meas_valid) begin
      next_st.latest[meas_channel] = meas_code;
    end
    next_st.cond = new_cond;
    // register writes; enables are shared by both addresses
    if (reg_wr) begin
      unique case (reg_addr)
        `ACMP_OFF_POWER_FIVE, `ACMP_OFF_CTRL_ALIAS: begin
          // both aliases land on the one enable store
          next_st.comparator_enable =
            reg_wdata[`ACMP_ENA_LSB +: 4];
        end
        `ACMP_OFF_INT_MASK: begin
          // a set mask bit only blocks the interrupt, the flag still sets
          next_st.comparator_event_mask =
            reg_wdata[`ACMP_FLAG_LSB +: 4];
        end
        `ACMP_OFF_CFG_ONE, `ACMP_OFF_CFG_TWO,
        `ACMP_OFF_CFG_THREE, `ACMP_OFF_CFG_FOUR: begin
          // the low two address bits pick the comparator; a new setting
          // takes effect on the next sample, stored verdicts stay put
          next_st.comparator_source_select[reg_addr[1:0]] =
            reg_wdata[`ACMP_SRC_MSB:`ACMP_SRC_LSB];
          next_st.comparator_above_select[reg_addr[1:0]] =
            reg_wdata[`ACMP_ABOVE_BIT];
          next_st.comparator_limit_value[reg_addr[1:0]] =
            reg_wdata[`ACMP_LIMIT_MSB:`ACMP_LIMIT_LSB];
        end
        default: begin
          // other addresses belong to other blocks
        end
      endcase
    end
    // flags clear on a status read, but a new edge in the same
    // cycle still sets its flag so no event is lost
    if (status_read) begin
      next_st.comparator_event_flag = rise;
    end else begin
      next_st.comparator_event_flag = st.comparator_event_flag | rise;
    end
    // gated event is built from the next flags, so it rises on the
    // same edge as the flag that causes it
    next_st.irq = |(next_st.comparator_event_flag
                    & ~next_st.comparator_event_mask);
    // read data: captured on the read strobe, zero elsewhere; the
    // registered port costs a cycle but keeps the pins on flops
    next_st.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `ACMP_OFF_POWER_FIVE, `ACMP_OFF_CTRL_ALIAS: begin
          next_st.rdata[`ACMP_ENA_LSB +: 4] = st.comparator_enable;
        end
        `ACMP_OFF_INT_STATUS: begin
          // flags as they stood before this read clears them
          next_st.rdata[`ACMP_FLAG_LSB +: 4] =
            st.comparator_event_flag;
        end
        `ACMP_OFF_INT_MASK: begin
          // mask bits share the positions of the flags
          next_st.rdata[`ACMP_FLAG_LSB +: 4] = st.comparator_event_mask;
        end
        `ACMP_OFF_CFG_ONE, `ACMP_OFF_CFG_TWO,
        `ACMP_OFF_CFG_THREE, `ACMP_OFF_CFG_FOUR: begin
          // config reads back exactly the word that was written
          next_st.rdata[`ACMP_SRC_MSB:`ACMP_SRC_LSB] =
            st.comparator_source_select[reg_addr[1:0]];
          next_st.rdata[`ACMP_ABOVE_BIT] =
            st.comparator_above_select[reg_addr[1:0]];
          next_st.rdata[`ACMP_LIMIT_MSB:`ACMP_LIMIT_LSB] =
            st.comparator_limit_value[reg_addr[1:0]];
        end
        default: begin
          // unmapped reads answer zero
          next_st.rdata = 16'h0000;
        end
      endcase
    end
  end

  // state register; all fields reset to constants
  // the asynchronous branch never loads a live signal
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < ACMP_CHANNELS; c++) begin
        st.latest[c] <= `ACMP_RST_CODE;
      end
      st.comparator_enable <= `ACMP_RST_ENABLE;
      for (int i = 0; i < NUM; i++) begin
        st.comparator_source_select[i] <= `ACMP_RST_SRC;
        st.comparator_above_select[i] <= `ACMP_RST_ABOVE;
        st.comparator_limit_value[i] <= `ACMP_RST_LIMIT;
      end
      // no verdict and no pending event survive a reset
      st.cond <= 4'h0;
      st.comparator_event_flag <= 4'h0;
      st.comparator_event_mask <= `ACMP_RST_MASK;
      st.rdata <= 16'h0000;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  // no logic sits between flop and pin, so the interrupt never glitches
  assign reg_rdata = st.rdata;
  assign comparator_event_flag = st.comparator_event_flag;
  assign comparator_irq = st.irq;

endmodule

// *** logic/acmp_consts.svh ***
`ifndef ACMP_CONSTS_SVH
`define ACMP_CONSTS_SVH

// register offsets on the control interface
`define ACMP_OFF_POWER_FIVE 8'h0C
`define ACMP_OFF_INT_STATUS 8'h1A
`define ACMP_OFF_INT_MASK 8'h22
`define ACMP_OFF_CTRL_ALIAS 8'hA3
`define ACMP_OFF_CFG_ONE 8'hA4
`define ACMP_OFF_CFG_TWO 8'hA5
`define ACMP_OFF_CFG_THREE 8'hA6
`define ACMP_OFF_CFG_FOUR 8'hA7

// field positions inside a comparator config word
`define ACMP_SRC_MSB 15
`define ACMP_SRC_LSB 13
`define ACMP_ABOVE_BIT 12
`define ACMP_LIMIT_MSB 11
`define ACMP_LIMIT_LSB 0

// enable bits 3:0, event flags and masks sit at bits 7:4
`define ACMP_ENA_LSB 0
`define ACMP_FLAG_LSB 4

// reset values
`define ACMP_RST_ENABLE 4'h0
`define ACMP_RST_SRC 3'h0
`define ACMP_RST_ABOVE 1'h0
`define ACMP_RST_LIMIT 12'h000
`define ACMP_RST_CODE 12'h000
`define ACMP_RST_MASK 4'h0

`endif

// *** logic/acmp_pkg.sv ***
package acmp_pkg;

  // number of comparators and of converter channels
  localparam int ACMP_NUM = 4;
  localparam int ACMP_CHANNELS = 8;

  typedef logic [11:0] acmp_code_t;
  typedef logic [7:0] acmp_addr_t;
  typedef logic [15:0] acmp_word_t;

  // converter channel codes used by the source select field
  typedef enum logic [2:0] {
    ACMP_SRC_EXT1 = 3'h0,
    ACMP_SRC_EXT2 = 3'h1,
    ACMP_SRC_EXT3 = 3'h2,
    ACMP_SRC_EXT4 = 3'h3,
    ACMP_SRC_USB = 3'h4,
    ACMP_SRC_LINE = 3'h5,
    ACMP_SRC_BATT = 3'h6,
    ACMP_SRC_TEMP = 3'h7
  } acmp_src_t;

  // whole state of the comparator block
  typedef struct packed {
    logic [ACMP_CHANNELS-1:0][11:0] latest;
    logic [ACMP_NUM-1:0] comparator_enable;
    logic [ACMP_NUM-1:0][2:0] comparator_source_select;
    logic [ACMP_NUM-1:0] comparator_above_select;
    logic [ACMP_NUM-1:0][11:0] comparator_limit_value;
    logic [ACMP_NUM-1:0] cond;
    logic [ACMP_NUM-1:0] comparator_event_flag;
    logic [ACMP_NUM-1:0] comparator_event_mask;
    logic [15:0] rdata;
    logic irq;
  } acmp_state_t;

endpackage

// *** logic/acmp_threshold.sv ***
`timescale 1ns/100ps
// one threshold test; equality never counts as beyond the limit
module acmp_threshold #(
  parameter int WIDTH = 12
) (
  input wire logic [WIDTH-1:0] code,
  input wire logic [WIDTH-1:0] limit,
  input wire logic above,
  output logic hit
);

  // raw codes compared unsigned, no scaling applied
  always_comb begin
    if (above) begin
      hit = (code > limit);
    end else begin
      hit = (code < limit);
    end
  end

endmodule

// *** dv/acmp_top_asserts.sv ***
`timescale 1ns/100ps
// port-level checker; sees only what crosses the block boundary
module acmp_top_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire acmp_pkg::acmp_addr_t reg_addr,
  input wire acmp_pkg::acmp_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire acmp_pkg::acmp_word_t reg_rdata,
  input wire logic meas_valid,
  input wire logic [2:0] meas_channel,
  input wire acmp_pkg::acmp_code_t meas_code,
  input wire logic [3:0] comparator_event_flag,
  input wire logic comparator_irq
);
  import acmp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a status read, and a read of either enable alias
  sequence stat_rd;
    reg_rd && reg_addr == 8'h1A;
  endsequence
  sequence ena_rd;
    reg_rd && reg_addr inside {8'h0C, 8'hA3};
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero without a read");
  ena_width_a: assert property (ena_rd |=> reg_rdata[15:4] == 12'h000)
    else $error("enable read shows bits above 3");
  stat_value_a: assert property (stat_rd |=>
    reg_rdata == {8'h00, $past(comparator_event_flag), 4'h0})
    else $error("status read differs from flags");
  stat_clear_a: assert property (stat_rd ##0 !meas_valid |=>
    comparator_event_flag == 4'h0) else $error("flags not cleared");
  flag_cause_a: assert property (|(comparator_event_flag &
    ~$past(comparator_event_flag)) |-> $past(meas_valid))
    else $error("flag rose without a sample");
  flag_sticky_a: assert property (|(~comparator_event_flag &
    $past(comparator_event_flag)) |-> $past(reg_rd && reg_addr == 8'h1A))
    else $error("flag fell without a status read");
  irq_src_a: assert property (comparator_irq |-> |comparator_event_flag)
    else $error("interrupt without a flag");
  irq_rise_a: assert property ($rose(comparator_irq) |->
    $past(meas_valid) || $past(reg_wr)) else $error("interrupt rose alone");
endmodule
bind acmp_top acmp_top_asserts acmp_top_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .meas_valid(meas_valid),
  .meas_channel(meas_channel), .meas_code(meas_code),
  .comparator_event_flag(comparator_event_flag),
  .comparator_irq(comparator_irq));

// *** dv/tb_acmp_top.sv ***
`timescale 1ns/100ps
module tb_acmp_top;
  import acmp_pkg::*;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, meas_valid = 0;
  acmp_addr_t reg_addr = 8'h00, a;
  acmp_word_t reg_wdata = 16'h0000, reg_rdata, e_rd = 16'h0000;
  logic [2:0] meas_channel = 3'h0, ch;
  acmp_code_t meas_code = 12'h000, c;
  logic [3:0] comparator_event_flag, ena = 0, msk = 0, cnd = 0, flg = 0;
  logic comparator_irq;
  acmp_word_t cfg [4] = '{default: 16'h0000};
  // every mapped place plus one unmapped address
  acmp_addr_t amap [9] = '{8'h0C, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7,
    8'h1A, 8'h22, 8'h55};
  // four comparators on one channel, equal-to-limit corners
  acmp_addr_t dir_a [5] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'h0C};
  acmp_word_t dir_d [5] = '{16'hF800, 16'hF7FF, 16'hE800, 16'hE801, 16'h000F};
  int failures = 0, checks_done = 0, r;
  acmp_top acmp_top_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_channel(meas_channel), .meas_code(meas_code),
    .comparator_event_flag(comparator_event_flag),
    .comparator_irq(comparator_irq));
  initial forever #10 core_clk = ~core_clk;
  task automatic check(input acmp_word_t got, input acmp_word_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // expected read data from the bench's own register image
  function automatic acmp_word_t rv(input acmp_addr_t x);
    case (x)
      8'h0C, 8'hA3: return {12'h000, ena};
      8'h1A: return {8'h00, flg, 4'h0};
      8'h22: return {8'h00, msk, 4'h0};
      8'hA4, 8'hA5, 8'hA6, 8'hA7: return cfg[x[1:0]];
      default: return 16'h0000;
    endcase
  endfunction
  // equality sits in neither direction
  function automatic logic beyond(input acmp_code_t v, input acmp_word_t w);
    return w[12] ? v > w[11:0] : v < w[11:0];
  endfunction
  // drives one cycle; checks the previous cycle's outcome, then models this one
  task automatic op(input logic wr, input logic rd, input logic mv,
    input acmp_addr_t ad, input acmp_word_t d, input logic [2:0] h,
    input acmp_code_t v);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= rd;
    meas_valid <= mv;
    reg_addr <= ad;
    reg_wdata <= d;
    meas_channel <= h;
    meas_code <= v;
    #1;
    check(reg_rdata, e_rd);
    check({12'h000, comparator_event_flag}, {12'h000, flg});
    check({15'h0000, comparator_irq}, {15'h0000, |(flg & ~msk)});
    e_rd = rd ? rv(ad) : 16'h0000;
    if (rd && ad == 8'h1A) flg = 4'h0;
    if (wr && (ad == 8'h0C || ad == 8'hA3)) cnd &= d[3:0];
    if (wr && (ad == 8'h0C || ad == 8'hA3)) ena = d[3:0];
    if (wr && ad == 8'h22) msk = d[7:4];
    if (wr && ad[7:2] == 6'h29) cfg[ad[1:0]] = d;
    for (int i = 0; i < 4; i++) begin
      if (mv && ena[i] && cfg[i][15:13] == h) begin
        if (beyond(v, cfg[i]) && !cnd[i]) flg[i] = 1'b1;
        cnd[i] = beyond(v, cfg[i]);
      end
    end
  endtask
  // whole run is some 420 cycles; allow ample margin
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(98));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (amap[k]) op(0, 1, 0, amap[k], 16'h0, 3'h0, 12'h000);
    $display("test reset done");
    op(1, 0, 0, 8'h0C, 16'hFFFF, 3'h0, 12'h000);
    op(0, 1, 0, 8'hA3, 16'h0, 3'h0, 12'h000);
    op(1, 0, 0, 8'h55, 16'hFFFF, 3'h0, 12'h000);
    op(0, 1, 0, 8'h55, 16'h0, 3'h0, 12'h000);
    foreach (dir_a[k]) op(1, 0, 0, dir_a[k], dir_d[k], 3'h0, 12'h000);
    op(0, 0, 1, 8'h00, 16'h0, 3'h7, 12'h800);
    op(0, 1, 1, 8'h1A, 16'h0, 3'h7, 12'h900);
    op(0, 1, 0, 8'h1A, 16'h0, 3'h0, 12'h000);
    $display("test directed done");
    repeat (400) begin
      r = $urandom_range(0, 15);
      a = amap[$urandom_range(0, 8)];
      c = r[3] ? cfg[r[1:0]][11:0] : 12'($urandom);
      ch = r[2] ? cfg[r[1:0]][15:13] : 3'($urandom);
      if (r < 3) op(1, 0, 0, a, 16'($urandom), 3'h0, 12'h000);
      else op(0, r < 6, 1, a, 16'h0, ch, c);
    end
    op(0, 0, 0, 8'h00, 16'h0, 3'h0, 12'h000);
    $display("test random done");
    summarize();
  end
endmodule
